// ===== logic/jlsm_pkg.sv
// Constants for the transmit lane mapper: mode codes, word and frame layouts.
// Assumes samples arrive one per channel per clock, already synchronous to clk.
// What this block does
// (R01) Mode 7: one 8-bit sample per octet, channels A-D on lanes 0-3, 64B/66B.
// (R02) Mode 8: 9-bit sample MSB first plus three zeros; two samples per lane, 64B/66B.
// (R03) Mode 9: two lanes per channel, even samples first lane, odd second, 8B/10B.
// (R04) Mode 10: sample plus one zero bit, four per five octets, two lanes per channel.
// (R05) Mode 11: dual/single only, four lanes per channel, five 12-bit words plus tail nibble.
// (R06) Mode 12: dual/single only, 8-bit samples over four lanes per channel, 64B/66B.
// (R07) Mode 13: dual/single only, 10-bit padded samples, four lanes, four per five octets.
// (R08) Receiver uses same mode, drops pad bits and tails, reorders samples by index; jlsm_rx_model only keeps lane 0's octets in use.
package jlsm_pkg;
  localparam int SAMPLE_W = 9;
  localparam int WORD_W = 12;
  localparam int FRAME_W = 64;
  localparam int LANES_MAX = 8;
  localparam int CHANNELS_MAX = 4;
  localparam int MODE_W = 4;
  localparam int BITS_W = 4;
  localparam int WORDS_W = 3;
  localparam int OCTETS_W = 4;
  localparam logic [3:0] MODE_8BIT_64B = 4'h7;
  localparam logic [3:0] MODE_12BIT_64B = 4'h8;
  localparam logic [3:0] MODE_8BIT_2LANE = 4'h9;
  localparam logic [3:0] MODE_10BIT_2LANE = 4'ha;
  localparam logic [3:0] MODE_12BIT_4LANE = 4'hb;
  localparam logic [3:0] MODE_8BIT_4LANE = 4'hc;
  localparam logic [3:0] MODE_10BIT_4LANE = 4'hd;
  localparam logic [3:0] MODE_RESET = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_10 = 4'ha;
  localparam logic [3:0] BITS_12 = 4'hc;
  localparam logic [2:0] WORDS_1 = 3'h1;
  localparam logic [2:0] WORDS_2 = 3'h2;
  localparam logic [2:0] WORDS_4 = 3'h4;
  localparam logic [2:0] WORDS_5 = 3'h5;
  localparam logic [3:0] OCTETS_1 = 4'h1;
  localparam logic [3:0] OCTETS_3 = 4'h3;
  localparam logic [3:0] OCTETS_5 = 4'h5;
  localparam logic [3:0] OCTETS_8 = 4'h8;
  localparam logic [1:0] SHIFT_1LANE = 2'h0;
  localparam logic [1:0] SHIFT_2LANE = 2'h1;
  localparam logic [1:0] SHIFT_4LANE = 2'h2;
endpackage : jlsm_pkg

// ===== logic/jlsm_lane_packer.sv
// One lane's packer: gathers padded sample words MSB first into a frame.
// Assumes the word is left aligned in WORD_W bits and flush clears any partial frame.
module jlsm_lane_packer #(
  parameter int FRAME_W = jlsm_pkg::FRAME_W,
  parameter int WORD_W = jlsm_pkg::WORD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic word_valid,
  input wire logic [WORD_W-1:0] word,
  input wire logic [jlsm_pkg::BITS_W-1:0] word_bits,
  input wire logic [jlsm_pkg::WORDS_W-1:0] frame_words,
  output logic [FRAME_W-1:0] frame_data,
  output logic frame_valid
);
  import jlsm_pkg::*;

  logic [FRAME_W-1:0] acc_reg;
  logic [FRAME_W-1:0] acc_next;
  logic [WORDS_W-1:0] cnt_reg;
  logic [FRAME_W-1:0] word_ext;
  logic [7:0] fill_bits;
  logic [7:0] left_shift;
  logic frame_done;

  // The word is right aligned before it joins the accumulator.
  assign word_ext = {{(FRAME_W-WORD_W){1'b0}}, word} >> (BITS_W'(WORD_W) - word_bits);
  assign acc_next = (acc_reg << word_bits) | word_ext;
  // Both factors are widened first so that 12 x 5 does not wrap in four bits.
  assign fill_bits = 8'(word_bits) * 8'(frame_words);
  assign left_shift = 8'(FRAME_W) - fill_bits;
  assign frame_done = word_valid && (cnt_reg == frame_words - 3'h1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg <= '0;
      cnt_reg <= '0;
      frame_data <= '0;
      frame_valid <= 1'b0;
    end
    else if (flush)
    begin
      acc_reg <= '0;
      cnt_reg <= '0;
      frame_valid <= 1'b0;
    end
    else
    begin
      frame_valid <= frame_done;
      if (word_valid)
      begin
        acc_reg <= frame_done ? '0 : acc_next;
        cnt_reg <= frame_done ? '0 : cnt_reg + 3'h1;
      end
      // Left aligned, so the unused low bits (tail nibble included) are zero.
      if (frame_done)
      begin
        frame_data <= acc_next << left_shift; // R05
      end
    end
  end
endmodule : jlsm_lane_packer

// ===== logic/jlsm_lane_mapper.sv
// Transmit lane mapper: spreads channel samples A-D over up to eight lanes.
// Assumes one sample per channel per clock; link layer and encoding follow it.
module jlsm_lane_mapper #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [jlsm_pkg::MODE_W-1:0] lane_map_mode_select,
  input wire logic sample_valid,
  input wire logic [jlsm_pkg::SAMPLE_W-1:0] sample_a,
  input wire logic [jlsm_pkg::SAMPLE_W-1:0] sample_b,
  input wire logic [jlsm_pkg::SAMPLE_W-1:0] sample_c,
  input wire logic [jlsm_pkg::SAMPLE_W-1:0] sample_d,
  output logic [jlsm_pkg::LANES_MAX-1:0][jlsm_pkg::FRAME_W-1:0] lane_frame,
  output logic [jlsm_pkg::LANES_MAX-1:0] lane_frame_valid,
  output logic [jlsm_pkg::OCTETS_W-1:0] lane_octets,
  output logic [jlsm_pkg::LANES_MAX-1:0] lane_active,
  output logic lane_enc_64b66b,
  output logic mode_error
);
  import jlsm_pkg::*;

  // Width in bits of one padded word for a mode.
  function automatic logic [BITS_W-1:0] word_bits_f(input logic [MODE_W-1:0] m);
    case (m)
      MODE_12BIT_64B, MODE_12BIT_4LANE: word_bits_f = BITS_12;
      MODE_10BIT_2LANE, MODE_10BIT_4LANE: word_bits_f = BITS_10;
      default: word_bits_f = BITS_8;
    endcase
  endfunction : word_bits_f

  // Words per lane frame for a mode.
  function automatic logic [WORDS_W-1:0] frame_words_f(input logic [MODE_W-1:0] m);
    case (m)
      MODE_12BIT_64B: frame_words_f = WORDS_2; // R02
      MODE_10BIT_2LANE, MODE_10BIT_4LANE: frame_words_f = WORDS_4; // R04 R07
      MODE_12BIT_4LANE: frame_words_f = WORDS_5; // R05
      default: frame_words_f = WORDS_1; // R01 R03 R06
    endcase
  endfunction : frame_words_f

  // Log2 of the lanes each channel uses in a mode.
  function automatic logic [1:0] lane_shift_f(input logic [MODE_W-1:0] m);
    case (m)
      MODE_8BIT_2LANE, MODE_10BIT_2LANE: lane_shift_f = SHIFT_2LANE; // R03 R04
      MODE_12BIT_4LANE, MODE_8BIT_4LANE, MODE_10BIT_4LANE: lane_shift_f = SHIFT_4LANE;
      default: lane_shift_f = SHIFT_1LANE; // R01 R02
    endcase
  endfunction : lane_shift_f

  // Octets carried in one lane frame.
  function automatic logic [OCTETS_W-1:0] octets_f(input logic [MODE_W-1:0] m);
    case (m)
      MODE_12BIT_64B: octets_f = OCTETS_3;
      MODE_10BIT_2LANE, MODE_10BIT_4LANE: octets_f = OCTETS_5;
      MODE_12BIT_4LANE: octets_f = OCTETS_8;
      default: octets_f = OCTETS_1;
    endcase
  endfunction : octets_f

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic [MODE_W-1:0] mode_reg;
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic mode_change;
  logic mode_in_range;
  logic mode_ok;
  logic take_sample;
  logic [BITS_W-1:0] word_bits;
  logic [WORDS_W-1:0] frame_words;
  logic [1:0] lane_shift;
  logic [2:0] sub_mask;
  logic [2:0] idx_sub;
  logic enc_64b;
  logic [LANES_MAX-1:0] active_next;
  logic [CHANNELS_MAX-1:0][SAMPLE_W-1:0] samples;
  logic [CHANNELS_MAX-1:0][WORD_W-1:0] words;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign mode_change = lane_map_mode_select != mode_reg;
  assign mode_in_range = (mode_reg >= MODE_8BIT_64B) && (mode_reg <= MODE_10BIT_4LANE);
  // Four-lane-per-channel modes do not exist on the quad part.
  assign mode_ok = mode_in_range &&
    ((mode_reg < MODE_12BIT_4LANE) || (NUM_CHANNELS < CHANNELS_MAX)); // R05 R06 R07
  // Samples that meet a mode change are dropped along with partial frames.
  assign take_sample = sample_valid && mode_ok && !mode_change;
  assign idx_next = take_sample ? idx_reg + 2'h1 : idx_reg;
  assign word_bits = word_bits_f(mode_reg);
  assign frame_words = frame_words_f(mode_reg);
  assign lane_shift = lane_shift_f(mode_reg);
  assign sub_mask = (3'h1 << lane_shift) - 3'h1;
  assign idx_sub = {1'b0, idx_reg} & sub_mask; // R03 R05 R06 R07
  assign enc_64b = (mode_reg == MODE_8BIT_64B) || (mode_reg == MODE_12BIT_64B) ||
    (mode_reg == MODE_8BIT_4LANE); // R01 R02 R06
  assign samples = {sample_d, sample_c, sample_b, sample_a};

  // Padding: 8-bit modes keep the upper bits, others append zeros after the LSB.
  genvar c;
  generate
    for (c = 0; c < CHANNELS_MAX; c++)
    begin : g_word
      assign words[c] = (word_bits == BITS_8) ? {samples[c][SAMPLE_W-1:1], 4'h0} : // R01
        (word_bits == BITS_10) ? {samples[c], 3'h0} : // R04 R07
        {samples[c], 3'h0}; // R02 R05
    end
  endgenerate

  // Lane l belongs to channel l >> shift and takes samples whose index matches l & mask.
  genvar l;
  generate
    for (l = 0; l < LANES_MAX; l++)
    begin : g_lane
      logic [2:0] ch;
      logic [2:0] sub;
      logic used;
      logic word_valid;
      assign ch = 3'(l) >> lane_shift;
      assign sub = 3'(l) & sub_mask;
      assign used = mode_ok && ({1'b0, ch} < 4'(NUM_CHANNELS));
      assign active_next[l] = used;
      assign word_valid = take_sample && used && (sub == idx_sub); // R03 R05 R06 R07
      jlsm_lane_packer #(
        .FRAME_W(FRAME_W),
        .WORD_W(WORD_W)
      ) u_packer (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .flush(mode_change),
        .word_valid(word_valid),
        .word(words[ch[1:0]]),
        .word_bits(word_bits),
        .frame_words(frame_words),
        .frame_data(lane_frame[l]),
        .frame_valid(lane_frame_valid[l])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      mode_reg <= MODE_RESET;
      idx_reg <= 2'h0;
      lane_octets <= OCTETS_1;
      lane_active <= '0;
      lane_enc_64b66b <= 1'b1;
      mode_error <= 1'b0;
    end
    else
    begin
      mode_reg <= lane_map_mode_select;
      idx_reg <= mode_change ? 2'h0 : idx_next;
      lane_octets <= octets_f(mode_reg);
      lane_active <= mode_change ? '0 : active_next;
      lane_enc_64b66b <= enc_64b;
      mode_error <= !mode_ok;
    end
  end
endmodule : jlsm_lane_mapper

// ===== sim/jlsm_lane_mapper_properties.sv
// Concurrent checks on the lane mapper's mode outputs and mode 7 frames.
// Assumes it is bound to the mapper and sees only its ports.
module jlsm_lane_mapper_properties #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] lane_map_mode_select,
  input wire logic sample_valid,
  input wire logic [8:0] sample_a,
  input wire logic [8:0] sample_b,
  input wire logic [8:0] sample_c,
  input wire logic [8:0] sample_d,
  input wire logic [7:0][63:0] lane_frame,
  input wire logic [7:0] lane_frame_valid,
  input wire logic [3:0] lane_octets,
  input wire logic [7:0] lane_active,
  input wire logic lane_enc_64b66b,
  input wire logic mode_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Six steady cycles cover the reset synchroniser and the mode pipeline.
  sequence steady(logic [3:0] m);
    (lane_map_mode_select == m && !mode_error) [*6];
  endsequence
  property fmt(logic [3:0] m, logic [3:0] oct, logic e, int k);
    steady(m) |-> lane_octets == oct && lane_enc_64b66b == e &&
      lane_active == 8'((1 << (NUM_CHANNELS * k)) - 1);
  endproperty
  chk_mode7_fmt: assert property (fmt(4'h7, 4'h1, 1'b1, 1))
    else $error("mode 7 format wrong");
  chk_mode8_fmt: assert property (fmt(4'h8, 4'h3, 1'b1, 1))
    else $error("mode 8 format wrong");
  chk_mode9_fmt: assert property (fmt(4'h9, 4'h1, 1'b0, 2))
    else $error("mode 9 format wrong");
  chk_mode10_fmt: assert property (fmt(4'ha, 4'h5, 1'b0, 2))
    else $error("mode 10 format wrong");
  chk_mode11_fmt: assert property (fmt(4'hb, 4'h8, 1'b0, 4))
    else $error("mode 11 format wrong");
  chk_mode12_fmt: assert property (fmt(4'hc, 4'h1, 1'b1, 4))
    else $error("mode 12 format wrong");
  chk_mode13_fmt: assert property (fmt(4'hd, 4'h5, 1'b0, 4))
    else $error("mode 13 format wrong");
  chk_mode7_frame: assert property (steady(4'h7) ##0 sample_valid |=> lane_frame_valid[0] &&
    lane_frame[0] == {$past(sample_a[8:1]), 56'h0})
    else $error("mode 7 lane 0 frame wrong");
  chk_mode7_lane1: assert property (steady(4'h7) ##0 (sample_valid && NUM_CHANNELS > 1) |=>
    lane_frame_valid[1] && lane_frame[1] == {$past(sample_b[8:1]), 56'h0})
    else $error("mode 7 lane 1 frame wrong");
  chk_error_quiet: assert property (mode_error |-> lane_frame_valid == 8'h0 &&
    lane_active == 8'h0)
    else $error("frame or active lane while mode invalid");
endmodule : jlsm_lane_mapper_properties

bind jlsm_lane_mapper jlsm_lane_mapper_properties #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (
  .clk(clk), .reset_n(reset_n), .lane_map_mode_select(lane_map_mode_select),
  .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
  .sample_c(sample_c), .sample_d(sample_d), .lane_frame(lane_frame),
  .lane_frame_valid(lane_frame_valid), .lane_octets(lane_octets), .lane_active(lane_active),
  .lane_enc_64b66b(lane_enc_64b66b), .mode_error(mode_error));

// ===== sim/jlsm_rx_model.sv
// Receiver stand-in: counts lane 0 frames, keeping only the octets in use.
// Assumes the same mode as the mapper.
module jlsm_rx_model (
  input wire logic clk,
  input wire logic [7:0][63:0] lane_frame,
  input wire logic [7:0] lane_frame_valid,
  input wire logic [3:0] lane_octets,
  output int frame_count,
  output logic [63:0] payload
);
  timeunit 1ns;
  timeprecision 1ps;
  initial frame_count = 0;
  always @(posedge clk)
    if (lane_frame_valid[0] === 1'b1)
    begin
      frame_count <= frame_count + 1;
      payload <= lane_frame[0] & ~(64'hffffffffffffffff >> (8 * lane_octets));
    end
endmodule : jlsm_rx_model

// ===== sim/test_jesd_lane_sample_mapper.sv
// Self-checking bench: dual part, every mode with random gapped samples.
// Assumes the mapper, its checker and the receiver model are compiled first.
module test_jesd_lane_sample_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  import jlsm_pkg::*;
  logic clk;
  logic reset_n;
  logic [3:0] mode;
  logic sample_valid;
  logic [8:0] sa, sb, sc, sd;
  logic [7:0][63:0] lane_frame;
  logic [7:0] lane_frame_valid, lane_active;
  logic [3:0] lane_octets;
  logic enc, mode_error;
  logic [63:0] exp_q[$];
  logic [63:0] rx_payload, last_f;
  int fail_count, n_tests, rx_count, sent;
  jlsm_lane_mapper #(.NUM_CHANNELS(2)) u_dut (.clk(clk), .reset_n(reset_n),
    .lane_map_mode_select(mode), .sample_valid(sample_valid), .sample_a(sa), .sample_b(sb),
    .sample_c(sc), .sample_d(sd), .lane_frame(lane_frame), .lane_frame_valid(lane_frame_valid),
    .lane_octets(lane_octets), .lane_active(lane_active), .lane_enc_64b66b(enc),
    .mode_error(mode_error));
  jlsm_rx_model u_rx (.clk(clk), .lane_frame(lane_frame), .lane_frame_valid(lane_frame_valid),
    .lane_octets(lane_octets), .frame_count(rx_count), .payload(rx_payload));
  task automatic check(string what, logic [63:0] seen, logic [63:0] want);
    n_tests++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Sends two lane 0 frames' worth of accepted samples, valid dropping at random.
  task automatic run_mode(logic [3:0] m, int k, int w, int bits, logic [3:0] oct, logic e);
    logic [63:0] f;
    int pos, nw, cnt;
    f = '0;
    pos = 64;
    nw = 0;
    cnt = 0;
    mode = m;
    repeat (8) @(negedge clk);
    check("octets", 64'(lane_octets), 64'(oct));
    check("encoding", 64'(enc), 64'(e));
    check("active", 64'(lane_active), 64'((1 << (2 * k)) - 1));
    check("error", 64'(mode_error), 64'h0);
    for (int t = 0; t < 400 && cnt < 2 * k * w; t++)
    begin
      sample_valid = ($urandom_range(3) != 0);
      sa = 9'($urandom);
      sb = 9'($urandom);
      sc = 9'($urandom);
      sd = 9'($urandom);
      if (sample_valid && cnt % k == 0)
      begin
        pos -= bits;
        f |= 64'(12'({sa, 3'h0}) >> (12 - bits)) << pos;
        nw++;
      end
      if (nw == w)
      begin
        exp_q.push_back(f);
        last_f = f;
        sent++;
        f = '0;
        pos = 64;
        nw = 0;
      end
      cnt += int'(sample_valid);
      @(negedge clk);
    end
    sample_valid = 1'b0;
    check("samples sent", 64'(cnt), 64'(2 * k * w));
    repeat (4) @(negedge clk);
  endtask : run_mode
  always @(negedge clk)
    if (lane_frame_valid[0] === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare frame", 64'h1, 64'h0);
      else
        check("lane 0 frame", lane_frame[0], exp_q.pop_front());
    end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    check("timeout", 64'h1, 64'h0);
    finish_test();
  end
  initial
  begin
    {reset_n, sample_valid, sa, sb, sc, sd, fail_count, n_tests, sent} = '0;
    mode = MODE_RESET;
    void'($urandom(32'h23a5));
    repeat (3) @(negedge clk);
    check("reset octets", 64'(lane_octets), 64'(OCTETS_1));
    check("reset encoding", 64'(enc), 64'h1);
    check("reset active", 64'(lane_active), 64'h0);
    check("reset error", 64'(mode_error), 64'h0);
    check("reset valid", 64'(lane_frame_valid), 64'h0);
    check("reset frame", lane_frame[0], 64'h0);
    reset_n = 1'b1;
    run_mode(MODE_8BIT_64B, 1, 1, 8, OCTETS_1, 1'b1);
    run_mode(MODE_12BIT_64B, 1, 2, 12, OCTETS_3, 1'b1);
    run_mode(MODE_8BIT_2LANE, 2, 1, 8, OCTETS_1, 1'b0);
    run_mode(MODE_10BIT_2LANE, 2, 4, 10, OCTETS_5, 1'b0);
    run_mode(MODE_12BIT_4LANE, 4, 5, 12, OCTETS_8, 1'b0);
    run_mode(MODE_8BIT_4LANE, 4, 1, 8, OCTETS_1, 1'b1);
    run_mode(MODE_10BIT_4LANE, 4, 4, 10, OCTETS_5, 1'b0);
    // An unknown mode code must raise the error and keep every lane quiet.
    mode = 4'he;
    repeat (8) @(negedge clk);
    check("bad mode error", 64'(mode_error), 64'h1);
    check("bad mode active", 64'(lane_active), 64'h0);
    sample_valid = 1'b1;
    repeat (4) @(negedge clk);
    sample_valid = 1'b0;
    repeat (2) @(negedge clk);
    run_mode(MODE_8BIT_64B, 1, 1, 8, OCTETS_1, 1'b1);
    check("frames received", 64'(rx_count), 64'(sent));
    check("rx payload", rx_payload, last_f);
    check("frames left", 64'(exp_q.size()), 64'h0);
    finish_test();
  end
endmodule : test_jesd_lane_sample_mapper
